/* common/tepct_defines.svh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * trigger/event/pulse timer. Assumes a 100 MHz system clock and a 32-bit
 * classic Wishbone register bus with word-aligned byte addresses.
 */
// Function
// - external trigger mode: wait for selected edge, then count source ticks
// - external trigger mode: compare match clears, halts, raises timer interrupt
// - stop-select 1: opposite edge before match clears and halts, no interrupt
// - stop-select 1: after halting, next trigger edge restarts count from zero
// - stop-select 0: opposite edge and repeat triggers ignored while counting
// - input filter drops pulses of four clocks or less; twelve always pass
// - low-speed and sleep modes bypass filter; one cycle pulse still needed
// - event mode: counter steps on each selected input edge
// - event mode: match tested on opposite edge; interrupt, clear, keep counting
// - auto-capture copies live count to capture register each counter step
// - window mode: count ticks gated by pin, selectable polarity; match clears
// - pulse-width mode starts on trigger edge; capture-edge field picks behaviour
// - single-edge: opposite edge captures, interrupts, loads one; trigger resumes
// - double-edge: capture on opposite edge and on trigger, then clear
// - single-edge: counter holds at one after capture until next edge
// - two-bit source select picks one of three prescaled source clocks
`ifndef TEPCT_DEFINES_SVH
`define TEPCT_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TEPCT_OFS_CTRL      4'h0
`define TEPCT_OFS_COMPARE  4'h4
`define TEPCT_OFS_CAPTURE  4'h8
`define TEPCT_OFS_COUNT    4'hc
`define TEPCT_ADDR_STATUS  5'h10

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define TEPCT_CTRL_W       10
`define TEPCT_STAT_RUN     0
`define TEPCT_STAT_SEEN    1
`define TEPCT_STAT_LEVEL   2
`define TEPCT_CTRL_RST     10'h000
`define TEPCT_COMPARE_RST  16'hffff

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TEPCT_CLK_MHZ      100
// prescaler shifts for source select codes 00, 01, 10
`define TEPCT_DIV_SH0      11
`define TEPCT_DIV_SH1      7
`define TEPCT_DIV_SH2      3
// noise rejection in system clock periods (reject at or below, pass at)
`define TEPCT_NOISE_MAX    4
`define TEPCT_PASS_MIN     12
`define TEPCT_FILT_CNT     (`TEPCT_NOISE_MAX + 1)

`endif

/* common/tepct_pkg.sv */
/*
 * Types for the trigger/event/pulse timer: modes, counter states and the
 * control register layout. Assumes tepct_defines.svh for widths.
 */
`include "tepct_defines.svh"
package tepct_pkg;

   typedef enum logic [1:0] {
      TEPCT_MODE_EXT_TRIG,
      TEPCT_MODE_EVENT,
      TEPCT_MODE_WINDOW,
      TEPCT_MODE_PULSE
   } tepct_mode_type;

   typedef enum logic {
      TEPCT_ST_HALT,
      TEPCT_ST_COUNT
   } tepct_state_type;

   // control register, bit 0 at the bottom
   typedef struct packed {
      logic           low_power;
      logic [1:0]     source_clock_select;
      logic           capture_edge_select;
      logic           auto_capture_enable;
      logic           trigger_stop_select;
      logic           run;
      logic           falling_sel;
      tepct_mode_type mode;
   } tepct_ctrl_type;

   // filtered view of the timer input pin
   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } tepct_pin_type;

endpackage : tepct_pkg

/* rtl/tepct_filter.sv */
/*
 * Noise rejection and edge detection for the timer input pin.
 * Assumes the pin is already synchronous to clk_i.
 */
`timescale 1ns/1ps
`include "tepct_defines.svh"
module tepct_filter #(
   parameter int FILT_CNT = `TEPCT_FILT_CNT
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // pin and mode
   input  wire logic              pin_i,
   input  wire logic              bypass_i,
   // filtered result
   output tepct_pkg::tepct_pin_type pin_o
);

   logic       level_q;
   logic       level_d;
   logic [3:0] stable_q;

   // ----------------------------------------------------------------------
   // level qualification
   // ----------------------------------------------------------------------
   // without bypass_i, a new level is accepted only after FILT_CNT equal samples in a row
   always_ff @(posedge clk_i) begin
      if (rst_i || pin_i == level_q) begin
         stable_q <= 4'h0;
      end else if (stable_q != 4'(FILT_CNT)) begin
         stable_q <= stable_q + 4'h1;
      end
   end

   always_comb begin
      level_d = level_q;
      if (bypass_i) begin
         level_d = pin_i;
      end else if (pin_i != level_q && stable_q == 4'(FILT_CNT - 1)) begin
         level_d = pin_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end

   // ----------------------------------------------------------------------
   // edge pulses, one clock wide
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= '0;
      end else begin
         pin_o.level <= level_d;
         pin_o.rise  <= level_d & ~level_q;
         pin_o.fall  <= ~level_d & level_q;
      end
   end

endmodule : tepct_filter

/* rtl/tepct_top.sv */
/*
 * Trigger/event/pulse timer: 16-bit up-counter with external trigger,
 * event, window and pulse-width modes, auto-capture, and a classic
 * Wishbone slave. Assumes the pin input is synchronous to clk_i.
 */
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tepct_defines.svh"
module tepct_top #(
   parameter int CNT_W    = 16,
   parameter int FILT_CNT = `TEPCT_FILT_CNT
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [4:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // timer pin and power mode
   input  wire logic              timer_input_pin_i,
   input  wire logic              low_speed_modes_i,
   input  wire logic              sleep_modes_i,
   // events
   output logic                   timer_match_irq_o
);

   localparam int CTRL_W = `TEPCT_CTRL_W;

   tepct_pkg::tepct_ctrl_type  timer_control_q;
   tepct_pkg::tepct_state_type state_q;
   tepct_pkg::tepct_pin_type   pin;
   logic [CNT_W-1:0]           compare_value_q;
   logic [CNT_W-1:0]           capture_value_q;
   logic [CNT_W-1:0]           count_q;
   logic [10:0]                presc_q;
   logic                       ack_q;
   logic                       seen_q;
   logic                       irq_q;
   logic [31:0]                wmask;
   logic                       wr_en;
   logic                       tick;
   logic                       trig_edge;
   logic                       opp_edge;
   logic                       gate_on;
   logic                       match;
   logic                       step;
   logic                       fire;
   logic                       grab;

   // ----------------------------------------------------------------------
   // input filter
   // ----------------------------------------------------------------------
   tepct_filter #(
      .FILT_CNT (FILT_CNT)
   ) u_filter (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .pin_i    (timer_input_pin_i),
      .bypass_i (timer_control_q.low_power | low_speed_modes_i |
                 sleep_modes_i),
      .pin_o    (pin)
   );

   assign trig_edge = timer_control_q.falling_sel ? pin.fall : pin.rise;
   assign opp_edge  = timer_control_q.falling_sel ? pin.rise : pin.fall;
   // window gate: falling_sel low means count while the pin is high
   assign gate_on   = pin.level ^ timer_control_q.falling_sel;
   assign match     = (count_q == compare_value_q);

   // ----------------------------------------------------------------------
   // source clock prescaler
   // ----------------------------------------------------------------------
   // free running so a restart does not shift the tick phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_q <= 11'h000;
      end else begin
         presc_q <= presc_q + 11'h001;
      end
   end

   always_comb begin
      case (timer_control_q.source_clock_select)
         2'b00:   tick = &presc_q[`TEPCT_DIV_SH0-1:0];
         2'b01:   tick = &presc_q[`TEPCT_DIV_SH1-1:0];
         default: tick = &presc_q[`TEPCT_DIV_SH2-1:0];
      endcase
   end

   // ----------------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
      end
   endgenerate

   // a write lands at the edge where the master samples ack high
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end
   assign wb_ack_o = ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         case (wb_adr_i)
            {1'b0, `TEPCT_OFS_CTRL}:
               wb_dat_o <= 32'(timer_control_q);
            {1'b0, `TEPCT_OFS_COMPARE}:
               wb_dat_o <= 32'(compare_value_q);
            {1'b0, `TEPCT_OFS_CAPTURE}:
               wb_dat_o <= 32'(capture_value_q);
            {1'b0, `TEPCT_OFS_COUNT}:
               wb_dat_o <= 32'(count_q);
            `TEPCT_ADDR_STATUS:
               wb_dat_o <= {29'h0, pin.level, seen_q,
                            state_q == tepct_pkg::TEPCT_ST_COUNT};
            default:
               wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_q <= `TEPCT_CTRL_RST;
      end else if (wr_en && wb_adr_i == {1'b0, `TEPCT_OFS_CTRL}) begin
         timer_control_q <= tepct_pkg::tepct_ctrl_type'(CTRL_W'(
            (32'(timer_control_q) & ~wmask) | (wb_dat_i & wmask)));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_value_q <= CNT_W'(`TEPCT_COMPARE_RST);
      end else if (wr_en && wb_adr_i == {1'b0, `TEPCT_OFS_COMPARE}) begin
         compare_value_q <= CNT_W'((32'(compare_value_q) & ~wmask) |
                                   (wb_dat_i & wmask));
      end
   end

   // sticky match flag, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_q <= 1'b0;
      end else if (fire) begin
         seen_q <= 1'b1;
      end else if (wr_en && wb_adr_i == `TEPCT_ADDR_STATUS && wb_sel_i[0] &&
                   wb_dat_i[`TEPCT_STAT_SEEN]) begin
         seen_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // counter state machine
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !timer_control_q.run) begin
         state_q <= tepct_pkg::TEPCT_ST_HALT;
         count_q <= '0;
      end else begin
         case (timer_control_q.mode)
            tepct_pkg::TEPCT_MODE_EXT_TRIG: begin
               case (state_q)
                  tepct_pkg::TEPCT_ST_HALT: begin
                     if (trig_edge) begin
                        state_q <= tepct_pkg::TEPCT_ST_COUNT;
                        count_q <= '0;
                     end
                  end
                  tepct_pkg::TEPCT_ST_COUNT: begin
                     if (tick && match) begin
                        state_q <= tepct_pkg::TEPCT_ST_HALT;
                        count_q <= '0;
                     end else if (opp_edge &&
                                  timer_control_q.trigger_stop_select) begin
                        state_q <= tepct_pkg::TEPCT_ST_HALT;
                        count_q <= '0;
                     end else if (tick) begin
                        // repeat triggers fall through unused
                        count_q <= count_q + 1'b1;
                     end
                  end
                  default: state_q <= tepct_pkg::TEPCT_ST_HALT;
               endcase
            end
            tepct_pkg::TEPCT_MODE_EVENT: begin
               state_q <= tepct_pkg::TEPCT_ST_COUNT;
               if (opp_edge && match) begin
                  count_q <= '0;
               end else if (trig_edge) begin
                  count_q <= count_q + 1'b1;
               end
            end
            tepct_pkg::TEPCT_MODE_WINDOW: begin
               state_q <= tepct_pkg::TEPCT_ST_COUNT;
               if (tick && gate_on) begin
                  count_q <= match ? '0 : count_q + 1'b1;
               end
            end
            tepct_pkg::TEPCT_MODE_PULSE: begin
               case (state_q)
                  tepct_pkg::TEPCT_ST_HALT: begin
                     // count_q keeps 1 after a single-edge capture
                     if (trig_edge) begin
                        state_q <= tepct_pkg::TEPCT_ST_COUNT;
                     end
                  end
                  tepct_pkg::TEPCT_ST_COUNT: begin
                     if (opp_edge && timer_control_q.capture_edge_select) begin
                        state_q <= tepct_pkg::TEPCT_ST_HALT;
                        count_q <= CNT_W'(1);
                     end else if (trig_edge &&
                                  !timer_control_q.capture_edge_select) begin
                        count_q <= '0;
                     end else if (tick) begin
                        count_q <= count_q + 1'b1;
                     end
                  end
                  default: state_q <= tepct_pkg::TEPCT_ST_HALT;
               endcase
            end
            default: state_q <= tepct_pkg::TEPCT_ST_HALT;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // interrupt and capture events
   // ----------------------------------------------------------------------
   always_comb begin
      fire = 1'b0;
      grab = 1'b0;
      step = 1'b0;
      if (timer_control_q.run) begin
         case (timer_control_q.mode)
            tepct_pkg::TEPCT_MODE_EXT_TRIG: begin
               step = state_q == tepct_pkg::TEPCT_ST_COUNT && tick;
               fire = step && match;
            end
            tepct_pkg::TEPCT_MODE_EVENT: begin
               step = trig_edge;
               fire = opp_edge && match;
            end
            tepct_pkg::TEPCT_MODE_WINDOW: begin
               step = tick && gate_on;
               fire = step && match;
            end
            tepct_pkg::TEPCT_MODE_PULSE: begin
               if (state_q == tepct_pkg::TEPCT_ST_COUNT) begin
                  step = tick;
                  grab = opp_edge ||
                         (trig_edge && !timer_control_q.capture_edge_select);
                  fire = grab;
               end
            end
            default: fire = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_value_q <= '0;
      end else if (grab) begin
         capture_value_q <= count_q;
      end else if (step && timer_control_q.auto_capture_enable) begin
         capture_value_q <= count_q;
      end
   end

   // one clock pulse per event
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= fire;
      end
   end
   assign timer_match_irq_o = irq_q;

endmodule : tepct_top

/* testbench/tepct_top_asserts.sv */
/* checker for tepct_top ports: bus handshake, read data, irq, pin level.
   assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module tepct_top_asserts (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone slave
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pin and events
   input wire logic        timer_input_pin_i,
   input wire logic        low_speed_modes_i,
   input wire logic        sleep_modes_i,
   input wire logic        timer_match_irq_o
);
   logic        req;
   logic        rd;
   logic        pin_q;
   logic [3:0]  still_q;
   logic [15:0] cmp_q;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd  = req & ~wb_we_i;
   // shadow of compare, so readback is judged against the writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_q <= 16'hffff;
      end else if (wb_we_i && wb_ack_o && wb_adr_i == 5'h04) begin
         if (wb_sel_i[0]) cmp_q[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) cmp_q[15:8] <= wb_dat_i[15:8];
      end
   end
   // cycles the pin has kept its level, saturating
   always_ff @(posedge clk_i) begin
      pin_q <= timer_input_pin_i;
      if (rst_i || timer_input_pin_i != pin_q) begin
         still_q <= 4'h0;
      end else if (still_q != 4'hf) begin
         still_q <= still_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
      !wb_ack_o && !timer_match_irq_o && wb_dat_o == 32'h0)
      else $error("outputs not quiet after reset");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_on_req: assert property (req |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_irq_one_cycle: assert property ($rose(timer_match_irq_o) |=>
      !timer_match_irq_o) else $error("irq longer than one cycle");
   a_unmapped_zero: assert property (rd && wb_adr_i >= 5'h14 |=>
      wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_upper_zero: assert property (rd && wb_adr_i inside {5'h04, 5'h08,
      5'h0c} |=> wb_dat_o[31:16] == 16'h0) else $error("wide count read");
   a_compare_back: assert property (rd && wb_adr_i == 5'h04 |=>
      wb_dat_o == {16'h0, cmp_q}) else $error("compare readback");
   a_pin_level: assert property (rd && wb_adr_i == 5'h10 &&
      still_q >= 4'hc |=> wb_dat_o[2] == $past(timer_input_pin_i))
      else $error("filtered level wrong");
endmodule : tepct_top_asserts

bind tepct_top tepct_top_asserts u_tepct_top_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .timer_input_pin_i(timer_input_pin_i),
   .low_speed_modes_i(low_speed_modes_i), .sleep_modes_i(sleep_modes_i),
   .timer_match_irq_o(timer_match_irq_o));

/* testbench/tepct_pulse_src.sv */
/* external pulse source on the timer input pin.
   assumes the bench calls hold() from one process only. */
`timescale 1ns/1ps
module tepct_pulse_src (
   // clock
   input  wire logic clk_i,
   // pin
   output logic      pin_o
);
   initial pin_o = 1'b0;
   // levels of 12 clocks or more, unless the bench wants noise or bypass
   task automatic hold(input logic v, input int n);
      @(posedge clk_i);
      pin_o <= v;
      repeat (n - 1) @(posedge clk_i);
   endtask : hold
endmodule : tepct_pulse_src

/* testbench/tb_tepct_top.sv */
/* self-checking bench for tepct_top: wishbone tasks reach the registers,
   tepct_pulse_src drives the pin. assumes a 100 MHz clock. */
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      total_checks++; \
      if ((g) !== (e)) begin \
         num_errors++; \
         $display("BAD %0t got %0h want %0h", $time, (g), (e)); \
      end \
   end
module tb_tepct_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [4:0]  wb_adr_i = 5'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        pin;
   logic        low_speed_modes_i = 1'b0;
   logic        sleep_modes_i = 1'b0;
   logic        timer_match_irq_o;
   logic [31:0] d;
   int          num_errors = 0;
   int          total_checks = 0;
   int          irq_cnt = 0;
   int          cyc_cnt = 0;
   int          irq0;
   int          cfg[5] = '{0, 0, 1, 2, 4};
   int          wid[5] = '{4, 12, 2, 2, 2};
   int          nclk[4] = '{4096, 1024, 256, 256};
   int          nexp[4] = '{2, 8, 32, 32};
   always #5 clk_i = ~clk_i;
   tepct_top u_tepct_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .timer_input_pin_i(pin), .low_speed_modes_i(low_speed_modes_i),
      .sleep_modes_i(sleep_modes_i), .timer_match_irq_o(timer_match_irq_o));
   tepct_pulse_src u_tepct_pulse_src (.clk_i(clk_i), .pin_o(pin));
   // irq sampled mid-cycle so the count never races the test process
   always @(negedge clk_i) if (timer_match_irq_o === 1'b1) irq_cnt++;
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000) begin
         num_errors++;
         finish_test();
      end
   end
   // ----------
   // tasks
   // ----------
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   task automatic bus(input logic we, input logic [4:0] a,
                      input logic [31:0] v, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= v;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      d = wb_dat_o;
      `CHK(wb_ack_o, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      bus(1'b1, a, v, 4'hf);
   endtask : wr
   task automatic rck(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      `CHK(d, e);
   endtask : rck
   task automatic rrng(input logic [4:0] a, input int lo, input int hi);
      bus(1'b0, a, 32'h0, 4'hf);
      `CHK(d >= lo && d <= hi, 1'b1);
   endtask : rrng
   task automatic p(input logic v, input int n);
      u_tepct_pulse_src.hold(v, n);
   endtask : p
   // ----------
   // tests
   // ----------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rck(5'h00, 32'h0);
      rck(5'h04, 32'h0000ffff);
      wr(5'h08, 32'h1234);
      rck(5'h08, 32'h0);
      bus(1'b1, 5'h04, 32'h1234, 4'h2);
      rck(5'h04, 32'h000012ff);
      wr(5'h14, 32'h55);
      rck(5'h14, 32'h0);
      $display("registers done");
      wr(5'h04, 32'hc);
      wr(5'h00, 32'h128);
      p(1'b0, 60);
      rck(5'h0c, 32'h0);
      irq0 = irq_cnt;
      p(1'b1, 20);
      rrng(5'h08, 1, 4);
      p(1'b0, 20);
      p(1'b1, 20);
      p(1'b0, 70);
      `CHK(irq_cnt - irq0, 1);
      rck(5'h0c, 32'h0);
      rck(5'h10, 32'h2);
      wr(5'h10, 32'h2);
      wr(5'h00, 32'h118);
      irq0 = irq_cnt;
      p(1'b1, 40);
      p(1'b0, 20);
      rck(5'h0c, 32'h0);
      rck(5'h10, 32'h0);
      p(1'b1, 130);
      p(1'b0, 20);
      `CHK(irq_cnt - irq0, 1);
      $display("trigger done");
      for (int fs = 0; fs < 2; fs++) begin
         wr(5'h00, 32'h0);
         wr(5'h04, 32'h3);
         wr(5'h00, 32'h009 | (32'(fs) << 2));
         irq0 = irq_cnt;
         for (int k = 0; k < 4; k++) begin
            if (k == 2) `CHK(irq_cnt - irq0, 0);
            p(1'b1, 20);
            p(1'b0, 20);
         end
         `CHK(irq_cnt - irq0, 1);
         rck(5'h0c, 32'h1);
      end
      for (int i = 0; i < 5; i++) begin
         wr(5'h00, 32'h0);
         wr(5'h00, 32'h009 | 32'((cfg[i] & 4) << 7));
         low_speed_modes_i <= cfg[i][0];
         sleep_modes_i     <= cfg[i][1];
         p(1'b1, wid[i]);
         p(1'b0, 20);
         rck(5'h0c, {31'h0, i != 0});
      end
      low_speed_modes_i <= 1'b0;
      sleep_modes_i     <= 1'b0;
      $display("event and filter done");
      for (int pol = 0; pol < 2; pol++) begin
         p(pol[0], 20);
         wr(5'h00, 32'h0);
         wr(5'h04, 32'h4);
         wr(5'h00, 32'h10a | (32'(pol) << 2));
         irq0 = irq_cnt;
         p(pol[0], 200);
         `CHK(irq_cnt - irq0, 0);
         p(!pol[0], 200);
         p(pol[0], 20);
         `CHK(irq_cnt - irq0 inside {[4:6]}, 1'b1);
      end
      p(1'b0, 20);
      for (int i = 0; i < 4; i++) begin
         wr(5'h00, 32'h0);
         wr(5'h04, 32'hffff);
         wr(5'h00, 32'h00a | (32'(i) << 7));
         p(1'b1, nclk[i]);
         p(1'b0, 20);
         rrng(5'h0c, nexp[i] - 1, nexp[i] + 1);
      end
      $display("window and rates done");
      wr(5'h00, 32'h0);
      wr(5'h00, 32'h14b);
      irq0 = irq_cnt;
      p(1'b1, 80);
      p(1'b0, 40);
      rrng(5'h08, 9, 11);
      rck(5'h0c, 32'h1);
      p(1'b1, 80);
      p(1'b0, 40);
      rrng(5'h08, 10, 12);
      `CHK(irq_cnt - irq0, 2);
      wr(5'h00, 32'h0);
      wr(5'h00, 32'h10b);
      irq0 = irq_cnt;
      p(1'b1, 80);
      p(1'b0, 30);
      rrng(5'h08, 9, 11);
      p(1'b0, 50);
      p(1'b1, 20);
      rrng(5'h08, 19, 22);
      `CHK(irq_cnt - irq0, 2);
      rrng(5'h0c, 1, 4);
      $display("pulse width done");
      finish_test();
   end
endmodule : tb_tepct_top
